// ==== logic/posdet_params.svh ====
`ifndef POSDET_PARAMS_SVH
`define POSDET_PARAMS_SVH
// Summary of operation
// - With the approach sensor required, missing it before the limit flags an error.
// - Search mode 0 may skip the approach sensor when configured without one.
// - Search modes 1, 2 and 3 always demand the approach sensor.
// - Limit input during origin search, origin on or not, flags origin-not-found.
// - A settable dwell delays completion so a slow host scan can see it.
// - A step code changes each time completion drops, showing the off state.
// - Deviation counter holds commanded minus actual position from feedback.
// - Deviation beyond counter capacity raises an overflow error.
// - Settable completion width; too small a width withholds completion.

// Register byte offsets.
`define ADDR_CTRL 8'h00
`define ADDR_WIDTH 8'h04
`define ADDR_DWELL 8'h08
`define ADDR_STATUS 8'h0C
`define ADDR_DEV 8'h10
`define ADDR_IRQ_STAT 8'h14
`define ADDR_IRQ_MASK 8'h18
`define ADDR_STEP 8'h1C

// Control register fields.
`define CTRL_START 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_APPR_REQ 3
`define CTRL_CLR_DEV 4

// Event bit positions in status and mask.
`define EV_APPR 0
`define EV_ORIG 1
`define EV_OVF 2
`define EV_DONE 3
`define EV_FOUND 4
`define EV_W 5

// Status register fields.
`define STAT_STATE_LO 0
`define STAT_STATE_HI 1
`define STAT_DONE 2
`define STAT_CMD 3

// Mode and reset values.
`define MODE_NO_APPR 2'h0
`define WIDTH_RST 16'h0010
`define DWELL_RST 16'h0000
`define DEV_LIMIT 18'h0_7FFF
`define HTRANS_NONSEQ_BIT 1
`endif

// ==== logic/posdet_pkg.sv ====
`default_nettype none
package posdet_pkg;
  // Origin search progress.
  typedef enum logic [1:0] {
    SRCH_IDLE = 2'b00,
    SRCH_APPROACH = 2'b01,
    SRCH_ORIGIN = 2'b10,
    SRCH_FOUND = 2'b11
  } search_state_t;
endpackage
`default_nettype wire

// ==== logic/posdet_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface posdet_if;
  logic cmd_up;
  logic cmd_dn;
  logic fb_up;
  logic fb_dn;
  logic clear;
  logic signed [15:0] count;
  logic [15:0] magnitude;
  logic overflow;
  logic in_window;
  logic [15:0] dwell;
  logic done;
  modport dev (input cmd_up, cmd_dn, fb_up, fb_dn, clear, output count, magnitude, overflow);
  modport dwl (input in_window, dwell, output done);
  modport top (output cmd_up, cmd_dn, fb_up, fb_dn, clear, in_window, dwell,
               input count, magnitude, overflow, done);
endinterface
`default_nettype wire

// ==== logic/dev_counter.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "posdet_params.svh"
module dev_counter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Counter link.
  posdet_if.dev bus
);
  logic signed [17:0] next_count;

  // Widened sum so a step past capacity is seen before it wraps.
  always_comb
  begin
    next_count = {{2{bus.count[15]}}, bus.count};
    if (bus.cmd_up) next_count = next_count + 18'sh0_0001;
    if (bus.cmd_dn) next_count = next_count - 18'sh0_0001;
    if (bus.fb_up) next_count = next_count - 18'sh0_0001;
    if (bus.fb_dn) next_count = next_count + 18'sh0_0001;
  end

  // The count holds at capacity rather than wrapping, so the sign stays true.
  always_ff @(posedge clk)
  begin
    if (rst || bus.clear)
    begin
      bus.count <= 16'sh0000;
      bus.overflow <= 1'h0;
    end
    else if (next_count > $signed(`DEV_LIMIT) || next_count < -$signed(`DEV_LIMIT))
    begin
      bus.overflow <= 1'h1;
    end
    else
    begin
      bus.count <= next_count[15:0];
      bus.overflow <= 1'h0;
    end
  end

  // Magnitude fits 16 bits because the count never reaches the most negative code.
  assign bus.magnitude = bus.count[15] ? $unsigned(-bus.count) : $unsigned(bus.count);
endmodule
`default_nettype wire

// ==== logic/dwell_timer.sv ====
`timescale 1ns/1ns
`default_nettype none
module dwell_timer (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Window and dwell link.
  posdet_if.dwl bus
);
  logic [15:0] held;

  // Completion rises only after the window has held for the dwell count.
  always_ff @(posedge clk)
  begin
    if (rst || !bus.in_window)
    begin
      held <= 16'h0000;
      bus.done <= 1'h0;
    end
    else if (held >= bus.dwell)
    begin
      bus.done <= 1'h1;
    end
    else
    begin
      held <= held + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ==== logic/posdet_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "posdet_params.svh"
module posdet_top (
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // AHB-Lite slave port.
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  // Command and feedback pulses.
  input wire logic I_CMD_FWD,
  input wire logic I_CMD_REV,
  input wire logic I_CMD_ACTIVE,
  input wire logic I_FB_FWD,
  input wire logic I_FB_REV,
  // Origin search sensors.
  input wire logic I_APPROACH,
  input wire logic I_ORIGIN,
  input wire logic I_LIMIT,
  // Status outputs.
  output logic O_DONE,
  output logic [7:0] O_STEP_CODE,
  output logic O_SEARCH_BUSY,
  output logic O_IRQ
);

  // Word decode shared by the write and read paths.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr[7:2] == off[7:2]);
  endfunction

  // Bus phase tracking.
  logic ap_valid;
  logic dp_write;
  logic [7:0] dp_addr;
  logic [31:0] next_rdata;

  // Software-visible state.
  logic [1:0] mode;
  logic appr_req;
  logic [15:0] width;
  logic [15:0] dwell;
  logic [`EV_W-1:0] irq_stat;
  logic [`EV_W-1:0] irq_mask;
  logic [`EV_W-1:0] next_irq_stat;
  logic [`EV_W-1:0] events;
  logic [7:0] step_code;

  // Write strobes decoded in the data phase.
  logic wr_ctrl;
  logic wr_width;
  logic wr_dwell;
  logic wr_irq_stat;
  logic wr_irq_mask;
  logic start;
  logic clr_dev;

  // Search machine and completion tracking.
  posdet_pkg::search_state_t state;
  posdet_pkg::search_state_t next_state;
  logic ev_appr;
  logic ev_orig;
  logic ev_found;
  logic done_q;

  posdet_if link ();

  // Deviation counter between command and feedback.
  dev_counter u_dev (
    .clk(I_SYS_CLK),
    .rst(I_RST),
    .bus(link.dev)
  );

  // Completion dwell.
  dwell_timer u_dwell (
    .clk(I_SYS_CLK),
    .rst(I_RST),
    .bus(link.dwl)
  );

  // An address phase is taken only while the bus is ready and a real transfer is marked.
  assign ap_valid = I_HSEL & I_HTRANS[`HTRANS_NONSEQ_BIT] & I_HREADY;

  // Remember the address phase so the write lands when its data arrives.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      dp_write <= 1'h0;
      dp_addr <= 8'h00;
    end
    else
    begin
      dp_write <= ap_valid & I_HWRITE;
      dp_addr <= I_HADDR[7:0];
    end
  end

  // The slave never stalls and never errors, so both answers are constant flops.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_HREADYOUT <= 1'h1;
      O_HRESP <= 1'h0;
    end
    else
    begin
      O_HREADYOUT <= 1'h1;
      O_HRESP <= 1'h0;
    end
  end

  // Data-phase write strobes; only whole-word writes are expected.
  assign wr_ctrl = dp_write & reg_hit(dp_addr, `ADDR_CTRL);
  assign wr_width = dp_write & reg_hit(dp_addr, `ADDR_WIDTH);
  assign wr_dwell = dp_write & reg_hit(dp_addr, `ADDR_DWELL);
  assign wr_irq_stat = dp_write & reg_hit(dp_addr, `ADDR_IRQ_STAT);
  assign wr_irq_mask = dp_write & reg_hit(dp_addr, `ADDR_IRQ_MASK);
  assign start = wr_ctrl & I_HWDATA[`CTRL_START];
  assign clr_dev = wr_ctrl & I_HWDATA[`CTRL_CLR_DEV];

  // Search configuration; start and clear bits are self-clearing strobes.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      mode <= 2'h0;
      appr_req <= 1'h0;
    end
    else if (wr_ctrl)
    begin
      mode <= I_HWDATA[`CTRL_MODE_HI:`CTRL_MODE_LO];
      appr_req <= I_HWDATA[`CTRL_APPR_REQ];
    end
  end

  // Completion width, compared against the deviation magnitude.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      width <= `WIDTH_RST;
    end
    else if (wr_width)
    begin
      width <= I_HWDATA[15:0];
    end
  end

  // Completion dwell in clock cycles.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      dwell <= `DWELL_RST;
    end
    else if (wr_dwell)
    begin
      dwell <= I_HWDATA[15:0];
    end
  end

  // Interrupt mask, same layout as the status bits.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      irq_mask <= {`EV_W{1'h0}};
    end
    else if (wr_irq_mask)
    begin
      irq_mask <= I_HWDATA[`EV_W-1:0];
    end
  end

  // Search transitions; a start decides from the written mode, since that field lands on the same edge.
  always_comb
  begin
    next_state = state;
    ev_appr = 1'h0;
    ev_orig = 1'h0;
    ev_found = 1'h0;
    case (state)
      posdet_pkg::SRCH_APPROACH:
      begin
        if (I_LIMIT)
        begin
          next_state = posdet_pkg::SRCH_IDLE;
          ev_appr = 1'h1;
        end
        else if (I_APPROACH)
        begin
          next_state = posdet_pkg::SRCH_ORIGIN;
        end
      end
      posdet_pkg::SRCH_ORIGIN:
      begin
        // Limit wins over a simultaneous origin, so a crowded end of travel is still caught.
        if (I_LIMIT)
        begin
          next_state = posdet_pkg::SRCH_IDLE;
          ev_orig = 1'h1;
        end
        else if (I_ORIGIN)
        begin
          next_state = posdet_pkg::SRCH_FOUND;
          ev_found = 1'h1;
        end
      end
      posdet_pkg::SRCH_IDLE,
      posdet_pkg::SRCH_FOUND:
      begin
        if (start && I_HWDATA[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_NO_APPR && !I_HWDATA[`CTRL_APPR_REQ])
        begin
          next_state = posdet_pkg::SRCH_ORIGIN;
        end
        else if (start)
        begin
          next_state = posdet_pkg::SRCH_APPROACH;
        end
      end
      default:
      begin
        next_state = posdet_pkg::SRCH_IDLE;
      end
    endcase
  end

  // Search state register.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      state <= posdet_pkg::SRCH_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Feed the deviation counter with command and feedback pulses.
  assign link.cmd_up = I_CMD_FWD;
  assign link.cmd_dn = I_CMD_REV;
  assign link.fb_up = I_FB_FWD;
  assign link.fb_dn = I_FB_REV;
  assign link.clear = clr_dev;
  assign link.dwell = dwell;

  // Window only counts once the command has ended; a small width may never be met.
  assign link.in_window = !I_CMD_ACTIVE && (link.magnitude <= width);

  // Completion output and its previous value for edge events.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      done_q <= 1'h0;
      O_DONE <= 1'h0;
    end
    else
    begin
      done_q <= link.done;
      O_DONE <= link.done;
    end
  end

  // Step code advances on each completion drop, so a slow host sees the off state.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      step_code <= 8'h00;
    end
    else if (done_q && !link.done)
    begin
      step_code <= step_code + 8'h01;
    end
  end

  // Event vector gathered for the sticky status.
  always_comb
  begin
    events = {`EV_W{1'h0}};
    events[`EV_APPR] = ev_appr;
    events[`EV_ORIG] = ev_orig;
    events[`EV_OVF] = link.overflow;
    events[`EV_DONE] = link.done & !done_q;
    events[`EV_FOUND] = ev_found;
  end

  // Write-one-to-clear, with a same-cycle event winning so nothing is lost.
  always_comb
  begin
    next_irq_stat = irq_stat;
    if (wr_irq_stat)
    begin
      next_irq_stat = irq_stat & ~I_HWDATA[`EV_W-1:0];
    end
    next_irq_stat = next_irq_stat | events;
  end

  // Sticky status register.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      irq_stat <= {`EV_W{1'h0}};
    end
    else
    begin
      irq_stat <= next_irq_stat;
    end
  end

  // Read mux built in the address phase so the data phase sees a flop.
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (ap_valid && !I_HWRITE)
    begin
      if (reg_hit(I_HADDR[7:0], `ADDR_CTRL))
      begin
        next_rdata[`CTRL_MODE_HI:`CTRL_MODE_LO] = mode;
        next_rdata[`CTRL_APPR_REQ] = appr_req;
      end
      else if (reg_hit(I_HADDR[7:0], `ADDR_WIDTH))
      begin
        next_rdata[15:0] = width;
      end
      else if (reg_hit(I_HADDR[7:0], `ADDR_DWELL))
      begin
        next_rdata[15:0] = dwell;
      end
      else if (reg_hit(I_HADDR[7:0], `ADDR_STATUS))
      begin
        next_rdata[`STAT_STATE_HI:`STAT_STATE_LO] = state;
        next_rdata[`STAT_DONE] = O_DONE;
        next_rdata[`STAT_CMD] = I_CMD_ACTIVE;
      end
      else if (reg_hit(I_HADDR[7:0], `ADDR_DEV))
      begin
        next_rdata = {{16{link.count[15]}}, link.count};
      end
      else if (reg_hit(I_HADDR[7:0], `ADDR_IRQ_STAT))
      begin
        next_rdata[`EV_W-1:0] = irq_stat;
      end
      else if (reg_hit(I_HADDR[7:0], `ADDR_IRQ_MASK))
      begin
        next_rdata[`EV_W-1:0] = irq_mask;
      end
      else if (reg_hit(I_HADDR[7:0], `ADDR_STEP))
      begin
        next_rdata[7:0] = step_code;
      end
    end
  end

  // Read data flop; unmapped addresses and idle cycles read as zero.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_HRDATA <= 32'h0000_0000;
    end
    else
    begin
      O_HRDATA <= next_rdata;
    end
  end

  // Pin copies of step code and search activity.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_STEP_CODE <= 8'h00;
      O_SEARCH_BUSY <= 1'h0;
    end
    else
    begin
      O_STEP_CODE <= step_code;
      O_SEARCH_BUSY <= (next_state == posdet_pkg::SRCH_APPROACH) || (next_state == posdet_pkg::SRCH_ORIGIN);
    end
  end

  // Level interrupt from the masked next status, so it rises on the same edge as the status bit.
  always_ff @(posedge I_SYS_CLK)
  begin
    if (I_RST)
    begin
      O_IRQ <= 1'h0;
    end
    else
    begin
      O_IRQ <= |(next_irq_stat & irq_mask);
    end
  end

endmodule
`default_nettype wire

// ==== sim/servo_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module servo_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Command pulses and pacing.
  input wire logic i_fwd,
  input wire logic i_rev,
  input wire logic i_run,
  // Encoder feedback pulses.
  output logic o_fwd,
  output logic o_rev
);
  int lag;
  int eff;
  // Lag still owed once the feedback pulses already on the wire are counted.
  always_comb eff = lag - int'(o_fwd) + int'(o_rev);
  // The motor trails the command and repays at most one count a cycle; a stalled motor sends nothing.
  always @(posedge clk)
  begin
    lag <= rst ? 0 : eff + int'(i_fwd) - int'(i_rev);
    o_fwd <= !rst && i_run && eff > 0;
    o_rev <= !rst && i_run && eff < 0;
  end
endmodule
`default_nettype wire

// ==== sim/posdet_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module posdet_monitor (
  // Clock and reset.
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  // Bus signals.
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_HREADY,
  input wire logic [31:0] O_HRDATA,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  // Motion and search signals.
  input wire logic I_CMD_ACTIVE,
  input wire logic I_APPROACH,
  input wire logic I_ORIGIN,
  input wire logic I_LIMIT,
  input wire logic O_DONE,
  input wire logic [7:0] O_STEP_CODE,
  input wire logic O_SEARCH_BUSY
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);
  // The slave never stalls and never errors, so a master needs no retry path.
  a_bus_ready_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus answer wrong");
  a_rdata_idle_zero: assert property (!$past(I_HSEL && I_HTRANS[1] && !I_HWRITE && I_HREADY) |-> O_HRDATA == 32'h0)
    else $error("read data outside a read");
  // Search ends on the limit, or once approach and origin are both seen.
  a_limit_ends_search: assert property (O_SEARCH_BUSY && I_LIMIT |-> ##[1:2] !O_SEARCH_BUSY)
    else $error("search survived the limit");
  a_origin_ends_search: assert property ((O_SEARCH_BUSY && I_APPROACH && I_ORIGIN && !I_LIMIT)[*2] |-> ##[0:2] !O_SEARCH_BUSY)
    else $error("search missed the origin");
  // Completion only when the command is idle.
  a_cmd_blocks_done: assert property (I_CMD_ACTIVE[*3] |-> !O_DONE)
    else $error("done while commanding");
  a_done_needs_idle: assert property (O_DONE |-> !$past(I_CMD_ACTIVE, 2) || !$past(I_CMD_ACTIVE, 3))
    else $error("done without idle command");
  // The step code moves by one exactly after each completion fall.
  a_step_after_fall: assert property ($fell(O_DONE) && !$past(I_RST) |=> O_STEP_CODE == $past(O_STEP_CODE) + 8'h01)
    else $error("step code missed a fall");
  a_step_only_fall: assert property ($changed(O_STEP_CODE) |-> $past(O_DONE, 2) && !$past(O_DONE))
    else $error("step code moved alone");
endmodule
bind posdet_top posdet_monitor mon (.I_SYS_CLK, .I_RST, .I_HSEL, .I_HTRANS, .I_HWRITE, .I_HREADY, .O_HRDATA,
  .O_HREADYOUT, .O_HRESP, .I_CMD_ACTIVE, .I_APPROACH, .I_ORIGIN, .I_LIMIT, .O_DONE, .O_STEP_CODE, .O_SEARCH_BUSY);
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "posdet_params.svh"
module tb;
  logic clk = 0, rst = 1, hsel = 0, hw = 0, cf = 0, cr = 0, ca = 1, run = 1, ap = 0, og = 0, lm = 0;
  logic ff, fr, done, busy, irq, rdy, resp;
  logic [1:0] ht = 2'h0;
  logic [7:0] step;
  logic [31:0] ha = 32'h0, wd = 32'h0, rdat, q, seed = 32'hd6f6;
  int error_cnt = 0, checks_done = 0, n, d, s, t;
  always #20 clk = ~clk;
  posdet_top dut (.I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(ha), .I_HTRANS(ht), .I_HWRITE(hw),
    .I_HSIZE(3'h2), .I_HWDATA(wd), .I_HREADY(rdy), .O_HRDATA(rdat), .O_HREADYOUT(rdy), .O_HRESP(resp),
    .I_CMD_FWD(cf), .I_CMD_REV(cr), .I_CMD_ACTIVE(ca), .I_FB_FWD(ff), .I_FB_REV(fr), .I_APPROACH(ap),
    .I_ORIGIN(og), .I_LIMIT(lm), .O_DONE(done), .O_STEP_CODE(step), .O_SEARCH_BUSY(busy), .O_IRQ(irq));
  servo_model srv (.clk(clk), .rst(rst), .i_fwd(cf), .i_rev(cr), .i_run(run), .o_fwd(ff), .o_rev(fr));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Search state after start, equal to the error bit a limit then raises.
  function automatic logic [31:0] st_exp(input int m, input int a);
    return (m == 0 && a == 0) ? 32'h2 : 32'h1;
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic final_report();
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A wait that ran out is a fault and ends the run.
  task automatic bound(input int k);
    if (k <= 0)
    begin
      error_cnt++;
      final_report();
    end
  endtask
  // One word transfer, then an idle cycle so a read never sees a stale register.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    hsel <= 1'b1;
    ht <= 2'h2;
    hw <= w;
    ha <= {24'h0, a};
    k = 50;
    do @(posedge clk); while (rdy !== 1'b1 && --k > 0);
    bound(k);
    hsel <= 1'b0;
    ht <= 2'h0;
    wd <= v;
    k = 50;
    do @(posedge clk); while (rdy !== 1'b1 && --k > 0);
    bound(k);
    q = rdat;
    @(posedge clk);
  endtask
  task automatic wdone(input logic v);
    int k = 300;
    do @(posedge clk); while (done !== v && --k > 0);
    bound(k);
  endtask
  task automatic pulse(input int k, input logic rev);
    repeat (k)
    begin
      @(posedge clk);
      cf <= !rev;
      cr <= rev;
      @(posedge clk);
      cf <= 1'b0;
      cr <= 1'b0;
    end
    @(posedge clk);
  endtask
  // Main sequence.
  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    bus(0, `ADDR_WIDTH, 32'h0);
    chk("width reset", `WIDTH_RST, q);
    chk("bus response", 32'h0, resp);
    bus(1, 8'h20, 32'hffff_ffff);
    bus(0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test registers done");
    // Every mode with and without the approach sensor, each search ended by the limit.
    bus(1, `ADDR_IRQ_MASK, 32'h1f);
    for (s = 0; s < 8; s++)
    begin
      bus(1, `ADDR_CTRL, {28'h0, s[0], s[2:1], 1'b1});
      bus(0, `ADDR_STATUS, 32'h0);
      chk("search state", st_exp(s[2:1], s[0]), q & 32'h3);
      chk("search busy", 32'h1, busy);
      bus(0, `ADDR_CTRL, 32'h0);
      chk("search config", {28'h0, s[0], s[2:1], 1'b0}, q);
      og <= !s[0];
      lm <= 1'b1;
      @(posedge clk);
      bus(0, `ADDR_IRQ_STAT, 32'h0);
      chk("search error", st_exp(s[2:1], s[0]), q & 32'h1f);
      chk("error irq", 32'h1, irq);
      chk("search ended", 32'h0, busy);
      lm <= 1'b0;
      og <= 1'b0;
      bus(1, `ADDR_IRQ_STAT, 32'h1f);
    end
    $display("test search errors done");
    // A full search; the found event stays silent until unmasked.
    bus(1, `ADDR_IRQ_MASK, 32'h0);
    bus(1, `ADDR_CTRL, 32'h3);
    ap <= 1'b1;
    og <= 1'b1;
    repeat (2) @(posedge clk);
    bus(0, `ADDR_STATUS, 32'h0);
    chk("found state", 32'h3, q & 32'h3);
    chk("irq masked", 32'h0, irq);
    bus(1, `ADDR_IRQ_MASK, 32'h10);
    @(posedge clk);
    chk("irq found", 32'h1, irq);
    bus(1, `ADDR_IRQ_STAT, 32'h1f);
    @(posedge clk);
    chk("irq cleared", 32'h0, irq);
    ap <= 1'b0;
    og <= 1'b0;
    $display("test found done");
    // Random moves against a stalled motor, then released; completion waits out the dwell.
    bus(1, `ADDR_WIDTH, 32'h0);
    for (s = 0; s < 3; s++)
    begin
      d = (s == 0) ? 0 : xs() % 16;
      n = xs() % 200 + 1;
      bus(1, `ADDR_DWELL, d);
      bus(0, `ADDR_DWELL, 32'h0);
      chk("dwell", d, q);
      run <= 1'b0;
      ca <= 1'b1;
      pulse(n, s == 1);
      bus(0, `ADDR_DEV, 32'h0);
      chk("deviation", s == 1 ? -n : n, q);
      run <= 1'b1;
      t = 200;
      do bus(0, `ADDR_DEV, 32'h0); while (q !== 32'h0 && --t > 0);
      bound(t);
      ca <= 1'b0;
      t = 0;
      do @(posedge clk); while (done !== 1'b1 && ++t < 300);
      chk("dwell delay", d + 2, t);
      bus(0, `ADDR_STATUS, 32'h0);
      chk("status done", 32'h4, q & 32'hc);
      bus(0, `ADDR_IRQ_STAT, 32'h0);
      chk("done event", 32'h8, q & 32'h8);
      bus(1, `ADDR_IRQ_STAT, 32'h8);
      t = step;
      ca <= 1'b1;
      wdone(0);
      repeat (2) @(posedge clk);
      chk("step code", (t + 1) & 32'hff, step);
      bus(0, `ADDR_STEP, 32'h0);
      chk("step register", (t + 1) & 32'hff, q);
    end
    $display("test completion done");
    // Residual deviation above a zero width withholds completion until widened.
    run <= 1'b0;
    pulse(3, 0);
    ca <= 1'b0;
    repeat (40) @(posedge clk);
    chk("done withheld", 32'h0, done);
    bus(1, `ADDR_WIDTH, 32'h3);
    wdone(1);
    chk("done widened", 32'h1, done);
    bus(1, `ADDR_CTRL, 32'h10);
    bus(0, `ADDR_DEV, 32'h0);
    chk("cleared", 32'h0, q);
    $display("test width done");
    // Commanding far beyond the counter's reach while the motor is stalled.
    bus(1, `ADDR_IRQ_MASK, 32'h4);
    ca <= 1'b1;
    pulse(32768 + xs() % 64, 0);
    bus(0, `ADDR_DEV, 32'h0);
    chk("dev held", 32'h7fff, q);
    chk("overflow irq", 32'h1, irq);
    bus(0, `ADDR_IRQ_STAT, 32'h0);
    chk("overflow flag", 32'h4, q & 32'h4);
    $display("test overflow done");
    // A reset in mid-run returns outputs and registers to their idle values.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset irq", 32'h0, irq);
    chk("reset done", 32'h0, done);
    chk("reset step", 32'h0, step);
    chk("reset busy", 32'h0, busy);
    bus(0, `ADDR_DEV, 32'h0);
    chk("reset deviation", 32'h0, q);
    bus(0, `ADDR_WIDTH, 32'h0);
    chk("reset width", `WIDTH_RST, q);
    $display("test reset done");
    final_report();
  end
endmodule
`default_nettype wire
